/* File: core/usb_endpoint_count_reset_irq.sv */
// endpoint byte count, fifo reset and interrupt summary with avalon slave
`timescale 1ns/1ps
module usb_endpoint_count_reset_irq
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  // avalon-mm slave
  input  wire logic [9:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  // endpoint side from the serial engine
  input  wire logic [29:0] i_status_flags,
  input  wire logic        i_rx_done,
  input  wire logic [2:0]  i_rx_ep,
  input  wire logic [10:0] i_rx_len,
  input  wire logic [7:0]  i_fifo_rdata,
  // fifo data port
  output logic      [2:0]  o_endpoint_index,
  output logic      [7:0]  o_fifo_wdata,
  output logic             o_fifo_wr,
  output logic             o_fifo_rd,
  output logic      [5:0]  o_fifo_clear,
  // interrupts
  output logic             o_usb_irq,
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic        rst_meta_q;
  logic        rst_sync_q;
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire logic rst_n = rst_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle per access, answer on the second edge
  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  logic        ack_q;
  wire logic   req = (i_read | i_write) & ~ack_q;
  wire logic   wr  = i_write & req;
  wire logic   rd  = i_read & req;

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_waitrequest <= 1'b1;
    else
      o_waitrequest <= ~req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [2:0]  sel_q;
  logic [5:0]  fifo_rst_q;
  logic [5:0]  enables_q;
  logic [5:0]  mask_q;

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sel_q <= ep_count_pkg::RST_SELECT;
    else if (wr && hit(i_address, ep_count_pkg::IDX_SELECT))
      sel_q <= i_writedata[2:0];
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fifo_rst_q <= ep_count_pkg::RST_FIFO_RST;
    else if (wr && hit(i_address, ep_count_pkg::IDX_FIFO_RST))
      fifo_rst_q <= i_writedata[5:0];
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      enables_q <= ep_count_pkg::RST_ENABLES;
    else if (wr && hit(i_address, ep_count_pkg::IDX_ENABLES))
      enables_q <= i_writedata[5:0];
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_q <= ep_count_pkg::RST_MASK;
    else if (wr && hit(i_address, ep_count_pkg::IDX_IRQ_MASK))
      mask_q <= i_writedata[5:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // per endpoint byte counts and summary
  function automatic logic [5:0] ep_any(input logic [29:0] f);
    ep_any = 6'h00;
    for (int e = 0; e < ep_count_pkg::NUM_EP; e++)
      ep_any[e] = |f[e*ep_count_pkg::FLAG_W +: ep_count_pkg::FLAG_W];
  endfunction

  logic [10:0] count_q [ep_count_pkg::NUM_EP];
  logic [5:0]  summary_q;
  logic [5:0]  pend_q;
  wire logic [5:0] flag_any = ep_any(i_status_flags);

  genvar g;
  generate
    for (g = 0; g < ep_count_pkg::NUM_EP; g++)
    begin : g_ep
      always_ff @(posedge i_sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          count_q[g] <= ep_count_pkg::RST_COUNT;
        else if (i_rx_done && i_rx_ep == 3'(g))
          count_q[g] <= i_rx_len;
      end
      always_ff @(posedge i_sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          summary_q[g] <= 1'b0;
        else
          summary_q[g] <= flag_any[g];
      end
      always_ff @(posedge i_sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          pend_q[g] <= 1'b0;
        else if (~summary_q[g] & flag_any[g])
          pend_q[g] <= 1'b1;
        else if (wr && hit(i_address, ep_count_pkg::IDX_IRQ_STAT)
                 && i_writedata[g])
          pend_q[g] <= 1'b0;
      end
    end
  endgenerate

  wire logic [10:0] sel_count = (sel_q < 3'(ep_count_pkg::NUM_EP))
                                ? count_q[sel_q] : 11'h000;

  ////////////////////////////////////////////////////////////////////////////
  // read data
  logic [31:0] rdata_d;
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (hit(i_address, ep_count_pkg::IDX_SELECT))
      rdata_d[2:0] = sel_q;
    else if (hit(i_address, ep_count_pkg::IDX_FIFO_BYTE))
      rdata_d[7:0] = i_fifo_rdata;
    else if (hit(i_address, ep_count_pkg::IDX_FIFO_RST))
      rdata_d[5:0] = fifo_rst_q;
    else if (hit(i_address, ep_count_pkg::IDX_CNT_LOW))
      rdata_d[7:0] = sel_count[7:0];
    else if (hit(i_address, ep_count_pkg::IDX_CNT_HIGH))
      rdata_d[2:0] = sel_count[10:8];
    else if (hit(i_address, ep_count_pkg::IDX_SUMMARY))
      rdata_d[5:0] = summary_q;
    else if (hit(i_address, ep_count_pkg::IDX_ENABLES))
      rdata_d[5:0] = enables_q;
    else if (hit(i_address, ep_count_pkg::IDX_IRQ_STAT))
      rdata_d[5:0] = pend_q;
    else if (hit(i_address, ep_count_pkg::IDX_IRQ_MASK))
      rdata_d[5:0] = mask_q;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_readdata <= 32'h0000_0000;
    else if (rd)
      o_readdata <= rdata_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo data port and outputs
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_fifo_wr    <= 1'b0;
      o_fifo_rd    <= 1'b0;
      o_fifo_wdata <= 8'h00;
    end
    else
    begin
      o_fifo_wr <= wr && hit(i_address, ep_count_pkg::IDX_FIFO_BYTE);
      o_fifo_rd <= rd && hit(i_address, ep_count_pkg::IDX_FIFO_BYTE);
      if (wr)
        o_fifo_wdata <= i_writedata[7:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_endpoint_index <= 3'h0;
      o_fifo_clear     <= 6'h00;
      o_usb_irq        <= 1'b0;
      o_irq            <= 1'b0;
    end
    else
    begin
      o_endpoint_index <= sel_q;
      o_fifo_clear     <= fifo_rst_q;
      o_usb_irq        <= |(summary_q & enables_q);
      o_irq            <= |(pend_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_irq_gating: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    ##2 o_usb_irq == |(ep_any($past(i_status_flags, 2)) & $past(enables_q)))
    else $error("usb irq not summary and enable");

  chk_summary_follow: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (|i_status_flags[4:0]) |=> summary_q[0])
    else $error("summary bit not set by flag");

  chk_summary_clear: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (i_status_flags[4:0] == 5'h00) |=> !summary_q[0])
    else $error("summary bit not cleared");

  chk_count_load: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (i_rx_done && i_rx_ep == 3'd1) |=> count_q[1] == $past(i_rx_len))
    else $error("count not loaded");

  chk_high_zero: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (rd && hit(i_address, ep_count_pkg::IDX_CNT_HIGH))
      |=> o_readdata[31:3] == 29'h0)
    else $error("high count upper bits not zero");

  chk_rst_top_zero: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (rd && hit(i_address, ep_count_pkg::IDX_FIFO_RST))
      |=> o_readdata[7:6] == 2'b00)
    else $error("fifo reset bits seven six set");

  chk_fifo_clear: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (wr && hit(i_address, ep_count_pkg::IDX_FIFO_RST))
      |=> ##1 o_fifo_clear == $past(i_writedata[5:0], 2))
    else $error("fifo clear not following register");

  chk_summary_ro: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (rd && hit(i_address, ep_count_pkg::IDX_SUMMARY))
      |=> o_readdata[5:0] == $past(summary_q))
    else $error("summary read wrong");

  chk_select_low: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (rd && hit(i_address, ep_count_pkg::IDX_CNT_LOW))
      |=> o_readdata[7:0] == $past(sel_count[7:0]))
    else $error("low count read wrong");

  sequence s_one_wait;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  chk_wait_one: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    req |=> s_one_wait)
    else $error("waitrequest not one cycle low");

  chk_pend_set: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (!summary_q[0] && flag_any[0]) |=> pend_q[0])
    else $error("pending bit not set by new flag");

  chk_pend_clear: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (wr && hit(i_address, ep_count_pkg::IDX_IRQ_STAT) && i_writedata[2]
      && !(!summary_q[2] && flag_any[2])) |=> !pend_q[2])
    else $error("pending bit not cleared by write");

  chk_select_index: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (wr && hit(i_address, ep_count_pkg::IDX_SELECT))
      |=> ##1 o_endpoint_index == $past(i_writedata[2:0], 2))
    else $error("endpoint index not following select");

  sequence s_fifo_pulse;
    o_fifo_wr ##1 !o_fifo_wr;
  endsequence

  chk_fifo_pulse: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (wr && hit(i_address, ep_count_pkg::IDX_FIFO_BYTE)) |=> s_fifo_pulse)
    else $error("fifo write not a single pulse");

  chk_fifo_data: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (wr && hit(i_address, ep_count_pkg::IDX_FIFO_BYTE))
      |=> o_fifo_wdata == $past(i_writedata[7:0]))
    else $error("fifo write data wrong");

  chk_enable_write: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (wr && hit(i_address, ep_count_pkg::IDX_ENABLES))
      |=> enables_q == $past(i_writedata[5:0]))
    else $error("enable register not written");

  chk_high_read: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (rd && hit(i_address, ep_count_pkg::IDX_CNT_HIGH))
      |=> o_readdata[2:0] == $past(sel_count[10:8]))
    else $error("high count read wrong");

endmodule

/* File: core/ep_count_pkg.sv */
// constants for the endpoint count, fifo reset and interrupt summary block
package ep_count_pkg;
  localparam int          NUM_EP        = 6;
  localparam int          CNT_W         = 11;
  localparam int          FLAG_W        = 5;
  localparam int          ADDR_W        = 8;
  // register word indices (all offsets are word aligned: byte address is index * 4)
  localparam logic [7:0]  IDX_SELECT    = 8'hc7;
  localparam logic [7:0]  IDX_FIFO_BYTE = 8'hcf;
  localparam logic [7:0]  IDX_FIFO_RST  = 8'hd5;
  localparam logic [7:0]  IDX_CNT_LOW   = 8'he2;
  localparam logic [7:0]  IDX_CNT_HIGH  = 8'he3;
  localparam logic [7:0]  IDX_SUMMARY   = 8'hf8;
  localparam logic [7:0]  IDX_ENABLES   = 8'hf9;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'hfa;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'hfb;
  // reset values
  localparam logic [5:0]  RST_FIFO_RST  = 6'h00;
  localparam logic [5:0]  RST_ENABLES   = 6'h00;
  localparam logic [5:0]  RST_MASK      = 6'h00;
  localparam logic [2:0]  RST_SELECT    = 3'h0;
  localparam logic [10:0] RST_COUNT     = 11'h000;
  // field widths
  localparam int          SEL_W         = 3;
  localparam int          HIGH_W        = 3;
endpackage

/* File: verification/sie_model.sv */
// serial engine stand-in: endpoint flags, packet lengths, fifo bytes
`timescale 1ns/1ps
module sie_model
(
  // clock and selected endpoint
  input  wire logic        i_clk,
  input  wire logic [2:0]  i_ep,
  // engine outputs
  output logic      [29:0] o_flags,
  output logic             o_done,
  output logic      [2:0]  o_rx_ep,
  output logic      [10:0] o_len,
  output logic      [7:0]  o_byte
);
  initial
  begin
    o_flags = 30'h0;
    o_done  = 1'b0;
    o_rx_ep = 3'h0;
    o_len   = 11'h0;
  end
  // byte pattern names the endpoint it came from
  assign o_byte = {5'h15, i_ep};
  //////////////////////////////////
  // length and receive flag arrive together, then the bus goes stale
  task automatic packet(input logic [2:0] ep, input logic [10:0] len);
    @(posedge i_clk);
    o_done  <= 1'b1;
    o_rx_ep <= ep;
    o_len   <= len;
    o_flags <= o_flags | (30'h1 << (ep * 5 + 1));
    @(posedge i_clk);
    o_done  <= 1'b0;
    o_rx_ep <= ~ep;
    o_len   <= ~len;
  endtask
  task automatic set_flags(input logic [29:0] f);
    @(posedge i_clk);
    o_flags <= f;
  endtask
endmodule

/* File: verification/test_usb_endpoint_count_reset_irq.sv */
// self-checking bench for the endpoint count, fifo reset and summary block
`timescale 1ns/1ps
module test_usb_endpoint_count_reset_irq;
  logic        clk;
  logic        nrst;
  logic [9:0]  addr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wait_req;
  logic [29:0] flags;
  logic        done;
  logic [2:0]  rx_ep;
  logic [10:0] rx_len;
  logic [7:0]  fbyte;
  logic [2:0]  ep_idx;
  logic [7:0]  fwdata;
  logic        fwr;
  logic        frd;
  logic [5:0]  fclr;
  logic        usb_irq;
  logic        irq;
  logic [7:0]  wr_byte;
  logic [10:0] exp_len;
  logic [31:0] v;
  int          wr_seen = 0;
  int          rd_seen = 0;
  int          error_cnt = 0;
  int          n_tests = 0;
  usb_endpoint_count_reset_irq usb_endpoint_count_reset_irq_inst
  (
    .i_sys_clk(clk), .i_nrst(nrst), .i_address(addr), .i_read(rd_en),
    .i_write(wr_en), .i_writedata(wdata), .o_readdata(rdata),
    .o_waitrequest(wait_req), .i_status_flags(flags), .i_rx_done(done),
    .i_rx_ep(rx_ep), .i_rx_len(rx_len), .i_fifo_rdata(fbyte),
    .o_endpoint_index(ep_idx), .o_fifo_wdata(fwdata), .o_fifo_wr(fwr),
    .o_fifo_rd(frd), .o_fifo_clear(fclr), .o_usb_irq(usb_irq), .o_irq(irq)
  );
  sie_model sie_model_inst
  (
    .i_clk(clk), .i_ep(ep_idx), .o_flags(flags), .o_done(done),
    .o_rx_ep(rx_ep), .o_len(rx_len), .o_byte(fbyte)
  );
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (fwr === 1'b1)
    begin
      wr_byte <= fwdata;
      wr_seen <= wr_seen + 1;
    end
  always @(posedge clk)
    if (frd === 1'b1)
      rd_seen <= rd_seen + 1;
  //////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk);
    addr  <= {idx, 2'b00};
    rd_en <= ~w;
    wr_en <= w;
    wdata <= d;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (wait_req === 1'b0)
        break;
    end
    if (k == 20)
    begin
      error_cnt++;
      end_sim();
    end
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx,
                      input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, v);
    chk(nm, v, exp);
  endtask
  //////////////////////////////////
  initial
  begin
    nrst  = 1'b0;
    addr  = 10'h0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = 32'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk("fifo_rst", ep_count_pkg::IDX_FIFO_RST, 32'h0);
    rchk("cnt_lo", ep_count_pkg::IDX_CNT_LOW, 32'h0);
    rchk("summary", ep_count_pkg::IDX_SUMMARY, 32'h0);
    rchk("unmapped", 8'h10, 32'h0);
    for (int e = 0; e < 6; e++)
    begin
      bus(1'b1, ep_count_pkg::IDX_FIFO_RST, 32'h1 << e, v);
      repeat (2) @(posedge clk);
      chk("fifo_clear", {26'h0, fclr}, 32'h1 << e);
    end
    bus(1'b1, ep_count_pkg::IDX_FIFO_RST, 32'h3f, v);
    rchk("fifo_rst", ep_count_pkg::IDX_FIFO_RST, 32'h3f);
    bus(1'b1, ep_count_pkg::IDX_FIFO_RST, 32'h0, v);
    // lengths 0x7ff xor e*0x111 first (full-scale on endpoint zero only), endpoint five ends at zero
    for (int e = 0; e < 6; e++)
      sie_model_inst.packet(3'(e), 11'h7ff ^ 11'(e * 32'h111));
    sie_model_inst.packet(3'h5, 11'h0);
    for (int e = 0; e < 8; e++)
    begin
      exp_len = (e > 4) ? 11'h0 : 11'h7ff ^ 11'(e * 32'h111);
      bus(1'b1, ep_count_pkg::IDX_SELECT, e, v);
      rchk("cnt_lo", ep_count_pkg::IDX_CNT_LOW, exp_len[7:0]);
      rchk("cnt_hi", ep_count_pkg::IDX_CNT_HIGH, exp_len[10:8]);
    end
    rchk("summary", ep_count_pkg::IDX_SUMMARY, 32'h3f);
    bus(1'b1, ep_count_pkg::IDX_SUMMARY, 32'h0, v);
    rchk("summary", ep_count_pkg::IDX_SUMMARY, 32'h3f);
    for (int b = 0; b < 30; b++)
    begin
      sie_model_inst.set_flags(30'h1 << b);
      repeat (2) @(posedge clk);
      rchk("summary", ep_count_pkg::IDX_SUMMARY, 32'h1 << (b / 5));
    end
    sie_model_inst.set_flags(30'h1 << 10);
    bus(1'b1, ep_count_pkg::IDX_ENABLES, 32'h3b, v);
    repeat (3) @(posedge clk);
    chk("usb_irq", usb_irq, 32'h0);
    bus(1'b1, ep_count_pkg::IDX_ENABLES, 32'h04, v);
    repeat (3) @(posedge clk);
    chk("usb_irq", usb_irq, 32'h1);
    rchk("enables", ep_count_pkg::IDX_ENABLES, 32'h04);
    sie_model_inst.set_flags(30'h0);
    repeat (3) @(posedge clk);
    chk("usb_irq", usb_irq, 32'h0);
    rchk("summary", ep_count_pkg::IDX_SUMMARY, 32'h0);
    rchk("irq_stat", ep_count_pkg::IDX_IRQ_STAT, 32'h3f);
    chk("irq", irq, 32'h0);
    bus(1'b1, ep_count_pkg::IDX_IRQ_MASK, 32'h04, v);
    repeat (3) @(posedge clk);
    chk("irq", irq, 32'h1);
    bus(1'b1, ep_count_pkg::IDX_IRQ_STAT, 32'h04, v);
    repeat (3) @(posedge clk);
    chk("irq", irq, 32'h0);
    rchk("irq_stat", ep_count_pkg::IDX_IRQ_STAT, 32'h3b);
    bus(1'b1, ep_count_pkg::IDX_SELECT, 32'h3, v);
    rchk("select", ep_count_pkg::IDX_SELECT, 32'h3);
    bus(1'b1, ep_count_pkg::IDX_FIFO_BYTE, 32'ha5, v);
    repeat (2) @(posedge clk);
    chk("fifo_wdata", {24'h0, wr_byte}, 32'ha5);
    chk("fifo_writes", wr_seen, 32'h1);
    rchk("fifo_byte", ep_count_pkg::IDX_FIFO_BYTE, 32'hab);
    @(posedge clk);
    chk("fifo_reads", rd_seen, 32'h1);
    end_sim();
  end
endmodule
